// ### abu_unit.sv
// Accumulator bit and number conversion unit with a Wishbone slave.
// Assumes a classic Wishbone master on the same 125 MHz clock.
`timescale 1ns/1ps
module abu_unit
   import abu_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [ABU_AW-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [ABU_DW-1:0] wb_dat_in,
   output logic [ABU_DW-1:0] wb_dat_out,
   output logic wb_ack_out,
   output logic [ABU_DW-1:0] acc_out,
   output abu_flags_t flags_out
);

   function automatic logic [31:0] bcd_to_base2(input logic [31:0] v);
      logic [31:0] s;
      s = '0;
      for (int i = ABU_DIGITS - 1; i >= 0; i--) begin
         s = (s << 3) + (s << 1) + {28'h0, v[i*4 +: 4]};
      end
      return s;
   endfunction

   function automatic logic [39:0] base2_to_bcd(input logic [31:0] v);
      logic [39:0] d;
      d = '0;
      for (int i = ABU_DW - 1; i >= 0; i--) begin
         for (int j = 0; j < ABU_DAB_DIGITS; j++) begin
            if (d[j*4 +: 4] > 4'h4) begin
               d[j*4 +: 4] = d[j*4 +: 4] + 4'h3;
            end
         end
         d = {d[38:0], v[i]};
      end
      return d;
   endfunction

   function automatic logic [4:0] lowest_one(input logic [31:0] v);
      logic [4:0] p;
      p = '0;
      for (int i = ABU_DW - 1; i >= 0; i--) begin
         if (v[i]) begin
            p = 5'(i);
         end
      end
      return p;
   endfunction

   function automatic logic [4:0] highest_one(input logic [31:0] v);
      logic [4:0] p;
      p = '0;
      for (int i = 0; i < ABU_DW; i++) begin
         if (v[i]) begin
            p = 5'(i);
         end
      end
      return p;
   endfunction

   // Register state.
   logic [31:0] acc_q;
   logic [31:0] acc_d;
   logic [ABU_CNT_W-1:0] cnt_q;
   abu_op_t last_op_q;
   abu_flags_t flags_q;
   abu_flags_t flags_d;
   logic ack_q;
   logic [31:0] rdat_q;

   // Bus decode.
   wire req_go = wb_cyc_in & wb_stb_in & ~ack_q;
   wire wr_go = req_go & wb_we_in;
   wire hit_acc = wb_adr_in == ABU_OFS_ACC;
   wire hit_cnt = wb_adr_in == ABU_OFS_CNT;
   wire hit_cmd = wb_adr_in == ABU_OFS_CMD;
   wire hit_stat = wb_adr_in == ABU_OFS_STAT;
   wire wr_acc = wr_go & hit_acc;
   wire wr_cnt = wr_go & hit_cnt & wb_sel_in[0];
   wire op_go = wr_go & hit_cmd & wb_sel_in[0];
   abu_op_t op;
   assign op = abu_op_t'(wb_dat_in[3:0]);

   logic [31:0] acc_wr;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign acc_wr[g*8 +: 8] = wb_sel_in[g] ? wb_dat_in[g*8 +: 8]
                                                : acc_q[g*8 +: 8];
      end
   endgenerate

   wire [31:0] rd_mux =
      hit_acc ? acc_q :
      hit_cnt ? {26'h0, cnt_q} :
      hit_cmd ? {28'h0, last_op_q} :
      hit_stat ? {27'h0, flags_q} : 32'h0;

   // Rotates; a count of 32 wraps to zero and leaves the word as it was.
   wire [ABU_ROT_W-1:0] rot_n = cnt_q[ABU_ROT_W-1:0];
   wire [63:0] rot_l_w = {acc_q, acc_q} << rot_n;
   wire [63:0] rot_r_w = {acc_q, acc_q} >> rot_n;
   wire [31:0] rotate_left_op_res = rot_l_w[63:32];
   wire [31:0] rotate_right_op_res = rot_r_w[31:0];

   // Lowest set bit index.
   wire [31:0] lowest_set_bit_index_op_res = {27'h0, lowest_one(acc_q)};
   wire lowest_set_bit_index_op_multi = (acc_q & (acc_q - 32'h1)) != 32'h0;

   // Position expansion after repeated division by 32.
   logic [31:0] bit_position_expand_op_val;
   always_comb begin
      bit_position_expand_op_val = acc_q;
      for (int i = 0; i < ABU_DIV_STEPS; i++) begin
         if (bit_position_expand_op_val >= ABU_BASE32) begin
            bit_position_expand_op_val = bit_position_expand_op_val >> ABU_ROT_W;
         end
      end
   end
   wire [31:0] bit_position_expand_op_res = 32'h1 << bit_position_expand_op_val[ABU_ROT_W-1:0];

   // Decimal conversions.
   logic bcd_bad;
   always_comb begin
      bcd_bad = 1'b0;
      for (int i = 0; i < ABU_DIGITS; i++) begin
         if (acc_q[i*4 +: 4] > ABU_DIGIT_MAX) begin
            bcd_bad = 1'b1;
         end
      end
   end
   wire [31:0] acc_as_bin = bcd_to_base2(acc_q);
   wire [39:0] acc_as_bcd = base2_to_bcd(acc_q);
   wire bcd_wide = acc_as_bcd[39:32] != 8'h0;
   wire [31:0] cpl_bin = (acc_as_bin == 32'h0) ? 32'h0 :
                         ABU_TEN_POW8 - acc_as_bin;
   wire [39:0] cpl_bcd = base2_to_bcd(cpl_bin);

   // Float fields of the accumulator.
   wire f_sign = acc_q[31];
   wire [7:0] f_exp = acc_q[30:ABU_EXP_LSB];
   wire [23:0] f_man = {1'b1, acc_q[ABU_MAN_W-1:0]};
   wire f_valid = f_exp != ABU_EXP_MAX;

   // Integer to float, truncating bits below the mantissa.
   wire [4:0] msb_pos = highest_one(acc_q);
   wire [31:0] integer_to_float_op_norm = acc_q << (5'd31 - msb_pos);
   wire [7:0] integer_to_float_op_exp = {3'h0, msb_pos} + ABU_FLT_BIAS;
   wire [31:0] integer_to_float_op_res = (acc_q == 32'h0) ? 32'h0 :
                          {1'b0, integer_to_float_op_exp, integer_to_float_op_norm[30:8]};

   // Float to integer, truncating toward zero.
   wire [7:0] unb = f_exp - ABU_FLT_BIAS;
   wire [4:0] unb5 = unb[4:0];
   wire [31:0] man32 = {8'h0, f_man};
   wire [31:0] float_to_integer_op_mag = (unb5 >= 5'd23) ? man32 << (unb5 - 5'd23) :
                          man32 >> (5'd23 - unb5);
   wire float_to_integer_op_bad = ~f_valid | (f_exp > ABU_INT_EXP_LIM);
   wire [31:0] float_to_integer_op_res = (f_exp < ABU_FLT_BIAS) ? 32'h0 :
                          f_sign ? 32'h0 - float_to_integer_op_mag : float_to_integer_op_mag;

   // Degree to radian: multiply by pi/180, sign carried through.
   wire [7:0] k_exp = ABU_RAD_SCALE[30:ABU_EXP_LSB];
   wire [23:0] k_man = {1'b1, ABU_RAD_SCALE[ABU_MAN_W-1:0]};
   wire [47:0] prod = {24'h0, f_man} * {24'h0, k_man};
   wire signed [9:0] r_exp = $signed({2'b00, f_exp}) +
                             $signed({2'b00, k_exp}) -
                             $signed({2'b00, ABU_FLT_BIAS}) +
                             $signed({9'h0, prod[47]});
   wire [22:0] r_man = prod[47] ? prod[46:24] : prod[45:23];
   wire r_under = (f_exp == 8'h0) | (r_exp <= 10'sd0);
   wire r_over = r_exp >= $signed({2'b00, ABU_EXP_MAX});
   wire [31:0] degree_to_radian_op_res =
      r_under ? 32'h0 :
      r_over ? {f_sign, ABU_EXP_MAX, 23'h0} :
      {f_sign, r_exp[7:0], r_man};

   // Result and flag selection.
   logic [31:0] op_res;
   abu_flags_t op_flg;
   always_comb begin
      op_res = acc_q;
      op_flg = '0;
      unique case (op)
         ABU_OP_ROTATE_LEFT: op_res = rotate_left_op_res;
         ABU_OP_ROTATE_RIGHT: op_res = rotate_right_op_res;
         ABU_OP_LOWEST_SET_BIT_INDEX: begin
            op_res = lowest_set_bit_index_op_res;
            op_flg.operand_overflow_flag = lowest_set_bit_index_op_multi;
         end
         ABU_OP_BIT_POSITION_EXPAND: op_res = bit_position_expand_op_res;
         ABU_OP_DECIMAL_TO_BASE2: begin
            op_res = bcd_bad ? acc_q : acc_as_bin;
            op_flg.invalid_number_flag = bcd_bad;
         end
         ABU_OP_BINARY_TO_DECIMAL: begin
            op_res = acc_as_bcd[31:0];
            op_flg.operand_overflow_flag = bcd_wide;
         end
         ABU_OP_ONES_COMPLEMENT: op_res = ~acc_q;
         ABU_OP_DECIMAL_COMPLEMENT: begin
            op_res = bcd_bad ? acc_q : cpl_bcd[31:0];
         end
         ABU_OP_INTEGER_TO_FLOAT: op_res = integer_to_float_op_res;
         ABU_OP_FLOAT_TO_INTEGER: begin
            op_res = float_to_integer_op_bad ? acc_q : float_to_integer_op_res;
            op_flg.valid_float_flag = f_valid;
            op_flg.invalid_number_flag = float_to_integer_op_bad;
         end
         ABU_OP_DEGREE_TO_RADIAN: begin
            op_res = f_valid ? degree_to_radian_op_res : acc_q;
            op_flg.operand_overflow_flag = f_valid & r_over;
            op_flg.valid_float_flag = f_valid;
            op_flg.invalid_number_flag = ~f_valid;
         end
         default: op_res = acc_q;
      endcase
      op_flg.zero_result_flag = op_res == 32'h0;
      op_flg.negative_result_flag = op_res[31];
   end

   abu_flags_t op_mask;
   assign op_mask = abu_flag_mask(op);

   // Only the flags an operation reports are rewritten.
   assign flags_d = op_go ? ((flags_q & ~op_mask) | (op_flg & op_mask))
                          : flags_q;
   assign acc_d = op_go ? op_res :
                  wr_acc ? acc_wr : acc_q;

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         acc_q <= ABU_ACC_RST;
         flags_q <= ABU_FLAGS_RST;
      end else begin
         acc_q <= acc_d;
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q <= ABU_CNT_RST;
         last_op_q <= ABU_OP_NONE;
      end else begin
         if (wr_cnt) begin
            cnt_q <= wb_dat_in[ABU_CNT_W-1:0];
         end
         if (op_go) begin
            last_op_q <= op;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0;
      end else begin
         ack_q <= req_go;
         rdat_q <= (req_go & ~wb_we_in) ? rd_mux : 32'h0;
      end
   end

   assign wb_ack_out = ack_q;
   assign wb_dat_out = rdat_q;
   assign acc_out = acc_q;
   assign flags_out = flags_q;

endmodule

// ### abu_pkg.sv
// Package for the accumulator bit and number conversion unit.
// Assumes a 32-bit classic Wishbone register bus and one clock.
package abu_pkg;

   localparam int ABU_DW = 32;
   localparam int ABU_AW = 4;

   // Register byte offsets.
   localparam logic [ABU_AW-1:0] ABU_OFS_ACC = 4'h0;
   localparam logic [ABU_AW-1:0] ABU_OFS_CNT = 4'h4;
   localparam logic [ABU_AW-1:0] ABU_OFS_CMD = 4'h8;
   localparam logic [ABU_AW-1:0] ABU_OFS_STAT = 4'hc;

   localparam logic [31:0] ABU_ACC_RST = 32'h0000_0000;
   localparam logic [5:0] ABU_CNT_RST = 6'h01;
   localparam int ABU_CNT_W = 6;
   localparam int ABU_ROT_W = 5;

   // Float layout and constants.
   localparam int ABU_EXP_LSB = 23;
   localparam int ABU_MAN_W = 23;
   localparam logic [7:0] ABU_FLT_BIAS = 8'h7f;
   localparam logic [7:0] ABU_EXP_MAX = 8'hff;
   localparam logic [7:0] ABU_INT_EXP_LIM = 8'h9e;
   localparam logic [31:0] ABU_RAD_SCALE = 32'h3c8e_fa35;

   // Decimal constants.
   localparam logic [31:0] ABU_TEN_POW8 = 32'h05f5_e100;
   localparam logic [3:0] ABU_DIGIT_MAX = 4'h9;
   localparam int ABU_DIGITS = 8;
   localparam int ABU_DAB_DIGITS = 10;
   localparam int ABU_DIV_STEPS = 7;
   localparam logic [31:0] ABU_BASE32 = 32'h0000_0020;

   typedef enum logic [3:0] {
      ABU_OP_NONE = 4'b0000,
      ABU_OP_ROTATE_LEFT = 4'b0001,
      ABU_OP_ROTATE_RIGHT = 4'b0010,
      ABU_OP_LOWEST_SET_BIT_INDEX = 4'b0011,
      ABU_OP_BIT_POSITION_EXPAND = 4'b0100,
      ABU_OP_DECIMAL_TO_BASE2 = 4'b0101,
      ABU_OP_BINARY_TO_DECIMAL = 4'b0110,
      ABU_OP_ONES_COMPLEMENT = 4'b0111,
      ABU_OP_DECIMAL_COMPLEMENT = 4'b1000,
      ABU_OP_INTEGER_TO_FLOAT = 4'b1001,
      ABU_OP_FLOAT_TO_INTEGER = 4'b1010,
      ABU_OP_DEGREE_TO_RADIAN = 4'b1011
   } abu_op_t;

   typedef struct packed {
      logic operand_overflow_flag;
      logic zero_result_flag;
      logic negative_result_flag;
      logic valid_float_flag;
      logic invalid_number_flag;
   } abu_flags_t;

   localparam int ABU_FLAGS_W = 5;
   localparam abu_flags_t ABU_FLAGS_RST = '0;

   // Which flags each operation reports; the others keep their value.
   function automatic abu_flags_t abu_flag_mask(input abu_op_t op);
      abu_flags_t m;
      m = '0;
      unique case (op)
         ABU_OP_LOWEST_SET_BIT_INDEX: m = 5'b11100;
         ABU_OP_DECIMAL_TO_BASE2: m = 5'b01101;
         ABU_OP_BINARY_TO_DECIMAL: m = 5'b11100;
         ABU_OP_INTEGER_TO_FLOAT: m = 5'b01100;
         ABU_OP_FLOAT_TO_INTEGER: m = 5'b01111;
         ABU_OP_DEGREE_TO_RADIAN: m = 5'b11111;
         default: m = '0;
      endcase
      return m;
   endfunction

endpackage

// ### abu_monitor.sv
// Checker for the accumulator unit, bound to its top module.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module abu_monitor
   import abu_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [ABU_AW-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [ABU_DW-1:0] wb_dat_in,
   input wire logic [ABU_DW-1:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic [ABU_DW-1:0] acc_out,
   input wire abu_flags_t flags_out
);
   wire take = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire go = take & wb_we_in & (wb_adr_in == ABU_OFS_CMD) & wb_sel_in[0];
   wire [3:0] opc = wb_dat_in[3:0];
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   ack_timing_a: assert property (take |=> wb_ack_out)
      else $error("request not acked in one cycle");
   ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");
   ones_cpl_a: assert property (go && opc == 4'h7
      |=> acc_out == ~$past(acc_out)) else $error("complement wrong");
   flags_hold_a: assert property (go && opc == 4'h7
      |=> $stable(flags_out)) else $error("flags changed by complement");
   index_zero_a: assert property (go && opc == 4'h3 && acc_out < 2
      |=> acc_out == 32'h0) else $error("index of 0 or 1 not zero");
   index_ovf_a: assert property (go && opc == 4'h3
      && $countones(acc_out) > 1 |=> flags_out.operand_overflow_flag)
      else $error("overflow flag missing");
   zero_flag_a: assert property (go && opc == 4'h3
      |=> flags_out.zero_result_flag == (acc_out == 32'h0))
      else $error("zero flag wrong");
   expand_a: assert property (go && opc == 4'h4 && acc_out < 32
      |=> acc_out == (32'h1 << $past(acc_out[4:0])))
      else $error("expansion wrong");
   neg_flag_a: assert property (go && opc == 4'ha
      |=> flags_out.negative_result_flag == acc_out[31])
      else $error("negative flag wrong");
endmodule

// ### abu_seq_model.sv
// Sequencer model: a classic Wishbone master issuing unit accesses.
// Assumes the unit answers each request with an ack one clock later.
`timescale 1ns/1ps
module abu_seq_model
   import abu_pkg::*;
(
   input wire logic clk_in,
   input wire logic ack_in,
   input wire logic [31:0] rdat_in,
   output logic cyc_out,
   output logic stb_out,
   output logic we_out,
   output logic [ABU_AW-1:0] adr_out,
   output logic [3:0] sel_out,
   output logic [31:0] dat_out
);
   initial begin
      cyc_out = 1'b0;
      stb_out = 1'b0;
      we_out = 1'b0;
      adr_out = 4'h0;
      sel_out = 4'h0;
      dat_out = 32'h0;
   end
   task automatic xfer(input logic w, input logic [ABU_AW-1:0] a,
         input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_in);
      cyc_out <= 1'b1;
      stb_out <= 1'b1;
      we_out <= w;
      adr_out <= a;
      sel_out <= 4'hf;
      dat_out <= d;
      do @(posedge clk_in); while (ack_in !== 1'b1);
      q = rdat_in;
      cyc_out <= 1'b0;
      stb_out <= 1'b0;
      // Released address and data lines show an inverted value so stale data cannot pass.
      adr_out <= ~a;
      dat_out <= ~d;
   endtask
endmodule

// ### abu_unit_tb.sv
// Self-checking bench for the accumulator unit.
// Assumes the sequencer model and the checker are compiled first.
`timescale 1ns/1ps
module abu_unit_tb;
   import abu_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic cyc, stb, we, ack;
   logic [ABU_AW-1:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, acc, st, prev, v;
   abu_flags_t flags;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   always #4 ref_clk_in = ~ref_clk_in;
   abu_unit abu_unit_inst (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .acc_out(acc), .flags_out(flags));
   abu_seq_model abu_seq_model_inst (.clk_in(ref_clk_in), .ack_in(ack),
      .rdat_in(rdat), .cyc_out(cyc), .stb_out(stb), .we_out(we),
      .adr_out(adr), .sel_out(sel), .dat_out(wdat));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      abu_seq_model_inst.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      abu_seq_model_inst.xfer(1'b0, a, 32'h0, q);
   endtask
   task automatic run(input logic [3:0] op, input logic [31:0] a,
         input logic [31:0] exp);
      wr(ABU_OFS_ACC, a);
      wr(ABU_OFS_CMD, {28'h0, op});
      rd(ABU_OFS_ACC, v);
      chk(v, exp);
      chk(acc, exp);
      rd(ABU_OFS_STAT, st);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up();
      end
   end
   initial begin
      repeat (4) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      rd(ABU_OFS_ACC, v);
      chk(v, ABU_ACC_RST);
      rd(ABU_OFS_CNT, v);
      chk(v, 32'h1);
      rd(ABU_OFS_STAT, v);
      chk(v, 32'h0);
      wr(4'h2, 32'h5a5a_5a5a);
      rd(4'h2, v);
      chk(v, 32'h0);
      $display("test reset done");
      run(4'h1, 32'h8000_0001, 32'h0000_0003);
      wr(ABU_OFS_CNT, 32'h4);
      run(4'h2, 32'h0000_001f, 32'hf000_0001);
      wr(ABU_OFS_CNT, 32'h20);
      run(4'h1, 32'h1234_5678, 32'h1234_5678);
      $display("test rotate done");
      run(4'h3, 32'h8000_0000, 32'h0000_001f);
      chk(st & 32'h1c, 32'h0);
      run(4'h3, 32'h0000_0001, 32'h0);
      chk(st & 32'h1c, 32'h08);
      run(4'h3, 32'h0000_0a00, 32'h9);
      chk(st & 32'h1c, 32'h10);
      run(4'h4, 32'h0000_000f, 32'h0000_8000);
      run(4'h4, 32'h0000_01e0, 32'h0000_8000);
      $display("test bits done");
      run(4'h5, 32'h0000_1234, 32'h0000_04d2);
      run(4'h5, 32'h0000_00a0, 32'h0000_00a0);
      chk(st & 32'h1, 32'h1);
      prev = st;
      run(4'h7, 32'h0f0f_0000, 32'hf0f0_ffff);
      chk(st, prev);
      run(4'h6, 32'h0000_04d2, 32'h0000_1234);
      run(4'h8, 32'h0000_0001, 32'h9999_9999);
      $display("test decimal done");
      run(4'h9, 32'h0000_0001, 32'h3f80_0000);
      run(4'h9, 32'h0000_0a00, 32'h4520_0000);
      run(4'ha, 32'h4520_0000, 32'h0000_0a00);
      chk(st & 32'hf, 32'h2);
      run(4'ha, 32'hc000_0000, 32'hffff_fffe);
      chk(st & 32'hf, 32'h6);
      run(4'ha, 32'h7f80_0000, 32'h7f80_0000);
      chk(st & 32'h1, 32'h1);
      $display("test float done");
      run(4'hb, 32'h4334_0000, 32'h4049_0fda);
      chk(v >> 16, 32'h4049);
      run(4'hb, 32'hc434_0000, 32'hc149_0fda);
      chk(v >> 16, 32'hc149);
      rd(ABU_OFS_CMD, v);
      chk(v, 32'hb);
      prev = st;
      run(4'hc, 32'h1234_5678, 32'h1234_5678);
      chk(st, prev);
      $display("test radian done");
      rst_b_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      rd(ABU_OFS_ACC, v);
      chk(v, ABU_ACC_RST);
      rd(ABU_OFS_CNT, v);
      chk(v, 32'h1);
      rd(ABU_OFS_STAT, v);
      chk(v, 32'h0);
      $display("test second reset done");
      wrap_up();
   end
endmodule
bind abu_unit abu_monitor abu_monitor_inst (.ref_clk_in(ref_clk_in),
   .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
   .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .acc_out(acc_out), .flags_out(flags_out));
